// >>> core/dsa_consts.svh
`ifndef DSA_CONSTS_SVH
`define DSA_CONSTS_SVH
// Control word layout
`define DSA_CTRL_W 8
`define DSA_ADDR_TOP_BIT 5
`define DSA_ADDR_MID_BIT 4
`define DSA_ADDR_LOW_BIT 3
// Conversion framing in serial clocks
`define DSA_CONV_CLKS 16
`define DSA_CTRL_CLKS 8
`define DSA_TRACK_CLKS 3
`define DSA_DATA_FIRST_CLK 5
`define DSA_RES_W 12
// Serial clock limit and divider from the 125 MHz system clock
`define DSA_SYS_CLK_MHZ 125
`define DSA_SCLK_MAX_MHZ 8
`define DSA_SCLK_HALF_CYC ((`DSA_SYS_CLK_MHZ + 2 * `DSA_SCLK_MAX_MHZ - 1) / (2 * `DSA_SCLK_MAX_MHZ))
// Host register byte addresses
`define DSA_REG_CTRL 32'h0000_0000
`define DSA_REG_STATUS 32'h0000_0004
`define DSA_REG_RESULT 32'h0000_0008
// Host control fields
`define DSA_CTRL_START_BIT 0
`define DSA_CTRL_CHAN_BIT 1
`define DSA_CTRL_CONT_BIT 2
`define DSA_CTRL_STOP_BIT 3
`endif

// >>> core/dsa_pkg.sv
package dsa_pkg;
	typedef logic [11:0] dsa_result_t;
	typedef logic [7:0] dsa_ctrl_t;
	typedef enum logic [2:0]
	{
		DSA_IDLE = 3'b001,
		DSA_SHIFT = 3'b010,
		DSA_DONE = 3'b100
	} dsa_host_state_e;
endpackage

// >>> core/dsa_link_if.sv
`timescale 1ns/100ps
interface dsa_link_if;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout_o;
	logic dout_oe;
	modport device (input cs_n, input sclk, input din, output dout_o, output dout_oe);
	modport host (output cs_n, output sclk, output din, input dout_o, input dout_oe);
endinterface

// >>> core/dsa_device.sv
`timescale 1ns/100ps
`include "dsa_consts.svh"
// Operation
// [R1] Only bits 5..3 of control word count
// [R2] Address applies to the following conversion
// [R3] Mid 0: low bit picks input, default first
// [R4] Host never sends middle address bit set
// [R5] Result is 12-bit straight binary
// [R6] Powered while selected, down when deselected
// [R7] Power-down from 16th fall to next 1st
// [R8] Conversion is 16 clocks, back to back
// [R9] Keep converting while select stays low
// [R10] Host serial clock at most 8 MHz
// [R11] Frame holds whole multiples of 16 edges
// [R12] Control captured on first 8 rising edges
// [R13] Result MSB first from clock 5, else Z; dout_oe stays high while selected and clocks 1-4 drive 0
// [R14] First result after power-up from first input
// [R15] Channel address register persists across power-down
module dsa_device
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	dsa_link_if.device LINK,
	input wire dsa_pkg::dsa_result_t SAMPLE_FIRST_I,
	input wire dsa_pkg::dsa_result_t SAMPLE_SECOND_I,
	output logic POWERED_O,
	output logic TRACKING_O,
	output logic SEL_SECOND_O
);
	logic sclk_q;
	logic [4:0] clk_cnt;
	logic [2:0] chan_addr;
	logic [2:0] ctrl_shift;
	logic chan_second;
	logic [11:0] result_shift;
	logic in_conv;
	logic rise;
	logic fall;

	// Serial pins are synchronous to CLOCK_I; find sclk edges
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			sclk_q <= 1'b0;
		else
			sclk_q <= LINK.sclk;
	end
	assign rise = LINK.sclk & ~sclk_q & ~LINK.cs_n;
	assign fall = ~LINK.sclk & sclk_q & ~LINK.cs_n;

	// Rising-edge count inside a conversion; wraps every 16
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || LINK.cs_n)
			clk_cnt <= 5'h00;
		else if (rise)
			clk_cnt <= (clk_cnt == 5'(`DSA_CONV_CLKS)) ? 5'h01 : clk_cnt + 5'h01; // [R8] [R9]
	end

	// In conversion between its first fall and its 16th fall; the 16th fall follows rise 15
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || LINK.cs_n)
			in_conv <= 1'b0; // [R6]
		else if (fall && clk_cnt == 5'(`DSA_CONV_CLKS - 1))
			in_conv <= 1'b0; // [R7]
		else if (fall || (!in_conv && clk_cnt == 5'h00 && !LINK.sclk))
			in_conv <= 1'b1; // [R7]
	end

	// Address bits arrive on rising edges 3..5 of the word; rest ignored
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			ctrl_shift <= 3'h0;
		else if (rise && clk_cnt < 5'(`DSA_CTRL_CLKS)
			&& clk_cnt >= 5'(7 - `DSA_ADDR_TOP_BIT) && clk_cnt <= 5'(7 - `DSA_ADDR_LOW_BIT))
			ctrl_shift <= {ctrl_shift[1:0], LINK.din}; // [R1] [R12]
	end

	// Latched address survives power-down; first input after reset
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			chan_addr <= 3'h0; // [R14]
		else if (rise && clk_cnt == 5'(`DSA_CTRL_CLKS - 1))
			chan_addr <= ctrl_shift; // [R15]
	end

	// Channel taken at start of the next track phase
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			chan_second <= 1'b0; // [R14]
		else if (rise && clk_cnt == 5'h00)
			chan_second <= chan_addr[0]; // [R2] [R3]
		else if (rise && clk_cnt == 5'(`DSA_CONV_CLKS))
			chan_second <= chan_addr[0]; // [R2] [R3]
	end

	// Hold at end of track on fall 4; shift out MSB first from fall 6 onward
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
			result_shift <= 12'h000;
		else if (fall && clk_cnt == 5'(`DSA_TRACK_CLKS))
			result_shift <= chan_second ? SAMPLE_SECOND_I : SAMPLE_FIRST_I; // [R5]
		else if (fall && clk_cnt > 5'(`DSA_DATA_FIRST_CLK - 1))
			result_shift <= {result_shift[10:0], 1'b0}; // [R13]
	end

	// Output pin: driven only while selected
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			LINK.dout_o <= 1'b0;
			LINK.dout_oe <= 1'b0;
		end
		else
		begin
			LINK.dout_oe <= ~LINK.cs_n; // [R13]
			LINK.dout_o <= (clk_cnt >= 5'(`DSA_DATA_FIRST_CLK - 1)) ? result_shift[11] : 1'b0;
		end
	end

	// Status pins registered
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			POWERED_O <= 1'b0;
			TRACKING_O <= 1'b0;
			SEL_SECOND_O <= 1'b0;
		end
		else
		begin
			POWERED_O <= in_conv; // [R6] [R7]
			TRACKING_O <= in_conv && clk_cnt <= 5'(`DSA_TRACK_CLKS);
			SEL_SECOND_O <= chan_second;
		end
	end
endmodule

// >>> core/dsa_host.sv
`timescale 1ns/100ps
`include "dsa_consts.svh"
// Serial master with an AHB-Lite register slave
module dsa_host
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	dsa_link_if.host LINK,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O
);
	dsa_pkg::dsa_host_state_e state;
	logic [5:0] div_cnt;
	logic [4:0] bit_cnt;
	logic [7:0] ctrl_word;
	logic [11:0] rx;
	logic [11:0] result;
	logic chan;
	logic cont;
	logic start;
	logic stop;
	logic done;
	logic wr_pend;
	logic [31:0] wr_addr;
	logic half;

	// Control word with channel address in bits 5..3, mid bit always 0
	function automatic dsa_pkg::dsa_ctrl_t mk_ctrl(input logic c);
		mk_ctrl = 8'h00;
		mk_ctrl[`DSA_ADDR_LOW_BIT] = c; // [R1] [R4]
	endfunction

	// AHB-Lite slave: zero wait, OKAY only
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
			HRDATA_O <= 32'h0000_0000;
		end
		else
		begin
			wr_pend <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
			if (HSEL_I && HREADY_I && HTRANS_I[1])
				wr_addr <= HADDR_I;
			if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I)
				case (HADDR_I)
					`DSA_REG_CTRL: HRDATA_O <= {29'h0, cont, chan, 1'b0};
					`DSA_REG_STATUS: HRDATA_O <= {30'h0, done, state != dsa_pkg::DSA_IDLE};
					`DSA_REG_RESULT: HRDATA_O <= {20'h0, result};
					default: HRDATA_O <= 32'h0000_0000;
				endcase
		end
	end
	always_ff @(posedge CLOCK_I)
	begin
		HREADYOUT_O <= 1'b1;
		HRESP_O <= 1'b0;
	end

	// Register writes; start and stop are one-cycle pulses
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			chan <= 1'b0;
			cont <= 1'b0;
			start <= 1'b0;
			stop <= 1'b0;
		end
		else
		begin
			start <= wr_pend && wr_addr == `DSA_REG_CTRL && HWDATA_I[`DSA_CTRL_START_BIT];
			stop <= wr_pend && wr_addr == `DSA_REG_CTRL && HWDATA_I[`DSA_CTRL_STOP_BIT];
			if (wr_pend && wr_addr == `DSA_REG_CTRL)
			begin
				chan <= HWDATA_I[`DSA_CTRL_CHAN_BIT];
				cont <= HWDATA_I[`DSA_CTRL_CONT_BIT];
			end
		end
	end

	// Half-period enable keeps sclk at or under 8 MHz
	assign half = div_cnt == 6'(`DSA_SCLK_HALF_CYC - 1);
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I || state != dsa_pkg::DSA_SHIFT || half)
			div_cnt <= 6'h00;
		else
			div_cnt <= div_cnt + 6'h01; // [R10]
	end

	// Frame sequencer: whole 16-clock conversions only
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			state <= dsa_pkg::DSA_IDLE;
			LINK.cs_n <= 1'b1;
			LINK.sclk <= 1'b1;
			LINK.din <= 1'b0;
			bit_cnt <= 5'h00;
			ctrl_word <= 8'h00;
			rx <= 12'h000;
			result <= 12'h000;
			done <= 1'b0;
		end
		else
		begin
			if (start)
				done <= 1'b0;
			case (state)
				dsa_pkg::DSA_IDLE:
				begin
					if (start)
					begin
						LINK.cs_n <= 1'b0; // [R11]
						ctrl_word <= mk_ctrl(chan);
						bit_cnt <= 5'h00;
						state <= dsa_pkg::DSA_SHIFT;
					end
				end
				dsa_pkg::DSA_SHIFT:
				begin
					if (half && LINK.sclk)
					begin
						LINK.sclk <= 1'b0;
						LINK.din <= bit_cnt < 5'(`DSA_CTRL_CLKS) ? ctrl_word[7] : 1'b0;
						ctrl_word <= {ctrl_word[6:0], 1'b0};
					end
					else if (half)
					begin
						LINK.sclk <= 1'b1;
						if (bit_cnt >= 5'(`DSA_DATA_FIRST_CLK - 1))
							rx <= {rx[10:0], LINK.dout_o};
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt == 5'(`DSA_CONV_CLKS - 1))
							state <= dsa_pkg::DSA_DONE; // [R8] [R11]
					end
				end
				dsa_pkg::DSA_DONE:
				begin
					result <= rx;
					done <= 1'b1;
					bit_cnt <= 5'h00;
					ctrl_word <= mk_ctrl(chan);
					if (cont && !stop)
						state <= dsa_pkg::DSA_SHIFT; // [R8]
					else
					begin
						LINK.cs_n <= 1'b1;
						state <= dsa_pkg::DSA_IDLE;
					end
				end
				default: state <= dsa_pkg::DSA_IDLE;
			endcase
		end
	end
endmodule

// >>> sim/dsa_link_properties.sv
`timescale 1ns/100ps
// Link checks beside the interface
module dsa_link_properties
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout_o,
	input wire logic dout_oe
);
	logic sclk_q;
	logic [7:0] rises;
	wire rise = sclk && !sclk_q && !cs_n;
	// Previous clock level
	always_ff @(posedge CLOCK_I)
		sclk_q <= sclk;
	// Rises in frame, low nibble wraps per conversion
	always_ff @(posedge CLOCK_I)
		rises <= (SYS_RST_I || cs_n) ? 8'h00 : rises + {7'h00, rise};
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	idle_hiz_a: assert property (cs_n && $past(cs_n) |-> !dout_oe)
		else $error("dout driven while deselected");
	sel_drive_a: assert property (!cs_n && $past(!cs_n, 3) |-> dout_oe)
		else $error("dout released while selected");
	clk_idle_a: assert property (cs_n && $past(cs_n) |-> sclk)
		else $error("sclk moves outside a frame");
	half_per_a: assert property ($changed(sclk) |=> $stable(sclk)[*7])
		else $error("sclk half period too short");
	whole_frame_a: assert property ($rose(cs_n) |-> rises[3:0] == 4'h0)
		else $error("frame not a multiple of 16 rises");
	din_hold_a: assert property (rise |-> $stable(din))
		else $error("din moved at sampling rise");
	mid_zero_a: assert property (rise && rises[3:0] == 4'h3 |-> !din)
		else $error("forbidden middle address bit sent");
	dout_hold_a: assert property (rise |-> $stable(dout_o))
		else $error("dout moved at sampling rise");
	cover property ($rose(cs_n));
	cover property (rise && rises[3:0] == 4'h3);
	cover property (rise && rises == 8'd16);
endmodule

// >>> sim/dual_channel_adc_serial_control_test.sv
`timescale 1ns/100ps
`include "dsa_consts.svh"
// Host over AHB-Lite, device on the far side of the link
module dual_channel_adc_serial_control_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic pwr;
	logic sel2;
	logic rd_ph = 1'b0;
	logic cur = 1'b0;
	logic [6:0] pat = 7'b0101011;
	dsa_pkg::dsa_result_t s1 = 12'h000;
	dsa_pkg::dsa_result_t s2 = 12'hfff;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	dsa_link_if lk();
	dsa_device u_dsa_device (.CLOCK_I(clk), .SYS_RST_I(rst), .LINK(lk), .SAMPLE_FIRST_I(s1),
		.SAMPLE_SECOND_I(s2), .POWERED_O(pwr), .TRACKING_O(), .SEL_SECOND_O(sel2));
	dsa_host u_dsa_host (.CLOCK_I(clk), .SYS_RST_I(rst), .LINK(lk), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp));
	dsa_link_properties u_dsa_link_properties (.CLOCK_I(clk), .SYS_RST_I(rst),
		.cs_n(lk.cs_n), .sclk(lk.sclk), .din(lk.din), .dout_o(lk.dout_o),
		.dout_oe(lk.dout_oe));
	initial forever #4 clk = ~clk;
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task close_out;
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One single transfer, address then data phase
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rd_ph <= !w;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		rd_ph <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0);
	endtask
	// Result belongs to the channel picked one conversion earlier
	task conv(input logic c);
		s1 <= 12'($urandom);
		s2 <= 12'($urandom);
		xfer(1'b1, `DSA_REG_CTRL, {30'h0, c, 1'b1});
		@(posedge lk.cs_n);
		@(posedge clk);
		chk("powered", 32'h0, 32'(pwr));
		chk("sel_second", 32'(cur), 32'(sel2));
		rd(`DSA_REG_RESULT, {20'h0, cur ? s2 : s1});
		cur = c;
	endtask
	// Read data against the oldest note
	always @(posedge clk)
		if (rd_ph && hready === 1'b1)
			chk("hrdata", exp_q.pop_front(), hrdata);
	initial
	begin
		void'($urandom(32'h88c1f51f));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// Unmapped place reads as zero
		rd(32'h0000_0010, 32'h0);
		for (int i = 0; i < 7; i++)
			conv(pat[i]);
		// Continuous run on the second input, then stop
		xfer(1'b1, `DSA_REG_CTRL, 32'h7);
		repeat (600) @(posedge clk);
		xfer(1'b1, `DSA_REG_CTRL, 32'h8);
		@(posedge lk.cs_n);
		@(posedge clk);
		rd(`DSA_REG_RESULT, {20'h0, s2});
		repeat (2) @(posedge clk);
		close_out();
	end
	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		close_out();
	end
endmodule
